/* File: logic/sleep_wakeup_control.sv */
// sleep entry, wake-up and status logic for the core
// Notes on behaviour
// - sleep ends on external reset, enabled watchdog wake, or enabled irq
// - external reset fully resets; other wakes resume program execution
// - power-down marker set at power-up, cleared by sleep instruction
// - expired flag cleared on a watchdog time-out with watchdog enabled, also a wake
// - second timer wakes only while running as asynchronous counter
// - converter done wakes only when clocked from its internal RC
// - low-voltage, comparator and port-change (amplifier) irqs all wake
// - other peripherals raise no interrupt while asleep
// - the next instruction word is fetched while sleep executes
// - irq wakes only if individually enabled, whatever the master enable
// - master enable clear: continue after sleep without vectoring
// - master enable set: run prefetched instruction then vector
// - pending enabled irq with master clear makes sleep a no-op
// - irq during or after sleep: sleep completes, then wakes at once
// - one instruction cycle is four oscillator periods
// - branch or true test takes two cycles, second a no-op
// - servicing irq clears master enable, pushes return, loads vector
// - watchdog time-out while asleep wakes instead of resetting
// - sleep clears watchdog, sets expired flag, stops oscillator driver
// - flags set on events regardless of any enable
`include "sleep_wakeup_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sleep_wakeup_control (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // external reset pin, active low, asynchronous to the clock
  input wire logic external_reset_pin_n_in,
  // register port
  input wire sleep_wakeup_pkg::reg_req_t reg_req_in,
  output logic [31:0] reg_rdata_out,
  // instruction stream from the core
  input wire sleep_wakeup_pkg::core_evt_t core_evt_in,
  // raw interrupt events, one per source
  input wire logic [`SW_NSRC-1:0] irq_event_in,
  // watchdog time-out pulse from its own oscillator path
  input wire logic watchdog_timeout_in,
  // to the core and clock tree
  output logic core_reset_out,
  output logic osc_driver_on_out,
  output logic exec_enable_out,
  output logic phase_tick_out,
  output logic watchdog_counter_clear_out,
  output logic prefetch_out,
  output logic [12:0] prefetch_pc_out,
  output logic vector_out,
  output logic [12:0] return_pc_out,
  output logic [12:0] vector_pc_out,
  output logic nop_cycle_out,
  output logic watchdog_reset_out
);
  import sleep_wakeup_pkg::*;

  // ------------------------------------------------------------------
  // pin conditioning
  // ------------------------------------------------------------------
  logic ext_level, wdt_level, wdt_prev_q;
  sync_three u_ext_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(external_reset_pin_n_in),
    .level_out(ext_level)
  );
  // the time-out comes from another oscillator, so it is synchronised too
  sync_three u_wdt_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pin_in(watchdog_timeout_in),
    .level_out(wdt_level)
  );
  logic ext_seen_q;
  wire wdt_evt = wdt_level & ~wdt_prev_q;
  // reset is only honoured once the synchronised pin has settled high
  wire ext_reset = ext_seen_q & ~ext_level;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [`SW_NSRC-1:0] enable_q, flags_q;
  logic pd_n_q, to_n_q;
  pwr_state_t state_q, state_d;
  logic [`SW_CNT_W-1:0] ost_q;
  logic [`SW_PH_W-1:0] phase_q;
  logic prefetch_q, nop_q;
  logic [12:0] pc_next_q;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire mie = ctrl_q[`SW_CTRL_MIE];
  wire wdt_en = ctrl_q[`SW_CTRL_WDT_EN];
  wire asleep = (state_q == ST_ASLEEP);
  wire wr_ctrl = reg_req_in.wr && reg_req_in.addr == `SW_REG_CTRL;
  wire wr_en = reg_req_in.wr && reg_req_in.addr == `SW_REG_ENABLE;
  wire wr_flags = reg_req_in.wr && reg_req_in.addr == `SW_REG_FLAGS;
  // which sources may fire at all while clocks are stopped
  logic [`SW_NSRC-1:0] sleep_capable;
  always_comb begin
    sleep_capable = '1;
    sleep_capable[`SW_SRC_TIMER2] = ctrl_q[`SW_CTRL_T2_ASYNC];
    sleep_capable[`SW_SRC_ADC] = ctrl_q[`SW_CTRL_ADC_RC];
    sleep_capable[`SW_SRC_OTHER] = 1'b0;
  end
  // clock-stopped sources are masked only while asleep
  wire [`SW_NSRC-1:0] live_evt = irq_event_in &
    (asleep ? sleep_capable : {`SW_NSRC{1'b1}});
  // flags pending with enables, master enable plays no part here
  wire irq_pend = |(flags_q & enable_q);
  wire sleep_exec = core_evt_in.sleep_op && exec_enable_out &&
    phase_tick_out;
  wire sleep_as_nop = sleep_exec && irq_pend && !mie;
  wire sleep_full = sleep_exec && !sleep_as_nop;
  wire wdt_wake = asleep && wdt_en && wdt_evt;
  wire wake = asleep && (irq_pend || wdt_wake);
  wire ost_done = (ost_q == '0);

  // ------------------------------------------------------------------
  // instruction-cycle phase divider
  // ------------------------------------------------------------------
  // one tick per four oscillator periods; stopped while asleep
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= '0;
    end else if (state_q != ST_RUN || core_reset_out) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + 1'b1;
    end
  end
  assign phase_tick_out = (phase_q == `SW_PH_W'(`SW_OSC_PER_CYC - 1));

  // ------------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_full) begin
          state_d = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (wake || irq_pend) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (ost_done) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_RUN;
    end else if (ext_reset) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // oscillator start-up timer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ost_q <= '0;
    end else if (state_q == ST_ASLEEP) begin
      ost_q <= `SW_CNT_W'(`SW_OST_CYC - 1);
    end else if (state_q == ST_WAKE && !ost_done) begin
      ost_q <= ost_q - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_n_q <= 1'b1;
      to_n_q <= 1'b1;
      wdt_prev_q <= 1'b0;
      ext_seen_q <= 1'b0;
    end else begin
      wdt_prev_q <= wdt_level;
      if (ext_level) begin
        ext_seen_q <= 1'b1;
      end
      if (sleep_full) begin
        pd_n_q <= 1'b0;
      end else if (ext_reset) begin
        pd_n_q <= 1'b1;
      end
      // a time-out wins over the set by sleep or reset
      if (wdt_evt && wdt_en) begin
        to_n_q <= 1'b0;
      end else if (sleep_full || ext_reset ||
                   (core_evt_in.wdt_clear_op && exec_enable_out)) begin
        to_n_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // control, enables and flags
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= '0;
      enable_q <= '0;
      flags_q <= '0;
    end else if (ext_reset) begin
      ctrl_q <= '0;
      enable_q <= '0;
      flags_q <= '0;
    end else begin
      if (wr_en) begin
        enable_q <= reg_req_in.wdata[`SW_NSRC-1:0];
      end
      // write one to clear; an event in the same cycle wins
      flags_q <= (flags_q & ~(wr_flags ? reg_req_in.wdata[`SW_NSRC-1:0] :
        {`SW_NSRC{1'b0}})) | live_evt;
      if (wr_ctrl) begin
        ctrl_q <= reg_req_in.wdata[3:0];
      end else if (vector_out) begin
        ctrl_q[`SW_CTRL_MIE] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // prefetch, resume and vectoring
  // ------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prefetch_q <= 1'b0;
      pc_next_q <= '0;
      nop_q <= 1'b0;
    end else begin
      prefetch_q <= sleep_exec;
      if (sleep_exec) begin
        pc_next_q <= core_evt_in.pc + 13'd1;
      end
      if (phase_tick_out) begin
        nop_q <= exec_enable_out && (core_evt_in.two_cycle || vector_out)
          && !nop_q;
      end
    end
  end
  // vector fires at the end of the instruction after sleep, or at the end of any
  // non-nop, non-sleep cycle the core runs with an enabled pending interrupt and master enable
  assign vector_out = exec_enable_out && phase_tick_out && !nop_q &&
    mie && irq_pend && !core_evt_in.sleep_op;
  assign vector_pc_out = `SW_VECTOR_PC;
  assign return_pc_out = core_evt_in.pc + 13'd1;
  assign prefetch_out = prefetch_q;
  assign prefetch_pc_out = pc_next_q;
  assign nop_cycle_out = nop_q;

  // ------------------------------------------------------------------
  // outputs to core and clock tree
  // ------------------------------------------------------------------
  assign core_reset_out = ext_reset;
  assign osc_driver_on_out = (state_q != ST_ASLEEP);
  assign exec_enable_out = (state_q == ST_RUN) && !core_reset_out;
  assign watchdog_counter_clear_out = sleep_full ||
    (core_evt_in.wdt_clear_op && exec_enable_out);
  // a time-out while running is a reset, while asleep only a wake, during start-up neither
  assign watchdog_reset_out = wdt_evt && wdt_en && !asleep &&
    state_q == ST_RUN;

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_req_in.addr)
      `SW_REG_CTRL: rd_mux[3:0] = ctrl_q;
      `SW_REG_ENABLE: rd_mux[`SW_NSRC-1:0] = enable_q;
      `SW_REG_FLAGS: rd_mux[`SW_NSRC-1:0] = flags_q;
      `SW_REG_STATUS: begin
        rd_mux[`SW_ST_PD_N] = pd_n_q;
        rd_mux[`SW_ST_TO_N] = to_n_q;
        rd_mux[`SW_ST_ASLEEP] = asleep;
        rd_mux[`SW_ST_HOLD] = (state_q == ST_WAKE);
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_req_in.rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata_out = rdata_q;
endmodule // sleep_wakeup_control
`default_nettype wire

/* File: logic/sleep_wakeup_cfg.svh */
// constants for the sleep and wake-up controller
`ifndef SLEEP_WAKEUP_CFG_SVH
`define SLEEP_WAKEUP_CFG_SVH
// register map (byte addresses, one word each)
`define SW_ADDR_W 4
`define SW_REG_CTRL 4'h0
`define SW_REG_ENABLE 4'h4
`define SW_REG_FLAGS 4'h8
`define SW_REG_STATUS 4'hC
// control register fields
`define SW_CTRL_MIE 0
`define SW_CTRL_WDT_EN 1
`define SW_CTRL_T2_ASYNC 2
`define SW_CTRL_ADC_RC 3
// status register fields
`define SW_ST_PD_N 0
`define SW_ST_TO_N 1
`define SW_ST_ASLEEP 2
`define SW_ST_HOLD 3
// number of wake sources and their slots
`define SW_NSRC 8
`define SW_SRC_EDGE 0
`define SW_SRC_PORT 1
`define SW_SRC_TIMER2 2
`define SW_SRC_ADC 3
`define SW_SRC_LVD 4
`define SW_SRC_CMP1 5
`define SW_SRC_CMP2 6
`define SW_SRC_OTHER 7
// timing
`define SW_CLK_MHZ 25
`define SW_OSC_PER_CYC 4
`define SW_OST_NS 40960
`define SW_OST_CYC ((`SW_OST_NS * `SW_CLK_MHZ + 999) / 1000)
`define SW_CNT_W 12
`define SW_PH_W 2
// interrupt vector address loaded on service
`define SW_VECTOR_PC 13'h0004
`endif

/* File: logic/sleep_wakeup_pkg.sv */
// types shared by the sleep and wake-up controller
`default_nettype none
package sleep_wakeup_pkg;
  // register port request from software
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // core-facing instruction stream events
  typedef struct packed {
    logic sleep_op;
    logic wdt_clear_op;
    logic two_cycle;
    logic [12:0] pc;
  } core_evt_t;
  typedef enum logic [1:0] {ST_RUN, ST_ASLEEP, ST_WAKE} pwr_state_t;
endpackage
`default_nettype wire

/* File: logic/sync_three.sv */
// three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/100ps
`default_nettype none
module sync_three (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q, s2_q, s3_q;
  // the first stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule // sync_three
`default_nettype wire

/* File: verification/sleep_wakeup_control_properties.sv */
// checker for the sleep and wake-up controller ports
`timescale 1ns/100ps
`default_nettype none
module sleep_wakeup_control_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // watched ports
  input wire sleep_wakeup_pkg::reg_req_t reg_req_in,
  input wire logic [31:0] reg_rdata_out,
  input wire sleep_wakeup_pkg::core_evt_t core_evt_in,
  input wire logic core_reset_out,
  input wire logic osc_driver_on_out,
  input wire logic exec_enable_out,
  input wire logic phase_tick_out,
  input wire logic watchdog_counter_clear_out,
  input wire logic prefetch_out,
  input wire logic [12:0] prefetch_pc_out,
  input wire logic vector_out,
  input wire logic [12:0] vector_pc_out,
  input wire logic watchdog_reset_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  AST_VEC_ADDR: assert property (
    vector_out |-> vector_pc_out == 13'h0004)
    else $error("vector address wrong");
  AST_TICK: assert property (phase_tick_out |=> !phase_tick_out [*3])
    else $error("instruction cycle not four clocks");
  AST_OSC_EXEC: assert property (
    !osc_driver_on_out |-> !exec_enable_out)
    else $error("executing with oscillator off");
  // clock must settle before the core runs again
  AST_OST: assert property (
    $rose(osc_driver_on_out) |-> !exec_enable_out [*8])
    else $error("execution resumed before start-up");
  AST_PIN: assert property (core_reset_out [*2] |-> !exec_enable_out)
    else $error("core runs under pin reset");
  AST_PREFETCH: assert property (
    prefetch_out |-> prefetch_pc_out == $past(core_evt_in.pc) + 13'h0001)
    else $error("prefetch address wrong");
  AST_WDT_RST: assert property (
    watchdog_reset_out |-> osc_driver_on_out)
    else $error("watchdog reset while asleep");
  AST_CLR: assert property (
    $fell(osc_driver_on_out) |-> watchdog_counter_clear_out ||
    $past(watchdog_counter_clear_out) ||
    $past(watchdog_counter_clear_out, 2))
    else $error("sleep did not clear watchdog");
  // status reads stand for one cycle only, so software sees a clean value
  AST_RDATA: assert property (
    !$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside its cycle");
endmodule // sleep_wakeup_control_properties
bind sleep_wakeup_control sleep_wakeup_control_properties props_u (.clk_in,
  .reset_n_in, .reg_req_in, .reg_rdata_out, .core_evt_in, .core_reset_out,
  .osc_driver_on_out,
  .exec_enable_out, .phase_tick_out, .watchdog_counter_clear_out, .prefetch_out,
  .prefetch_pc_out, .vector_out, .vector_pc_out, .watchdog_reset_out);
`default_nettype wire

/* File: verification/sleep_wakeup_control_bench.sv */
// self-checking bench for the sleep and wake-up controller
`include "sleep_wakeup_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sleep_wakeup_control_bench;
  import sleep_wakeup_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic pin_n = 1'b1;
  reg_req_t req = '0;
  core_evt_t evt = '{1'b0, 1'b0, 1'b0, 13'h0100};
  logic [7:0] irq = 8'h00;
  logic wdt_to = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic core_rst, osc_on, exec_en, tick, wclr, pf, vec, nop, wrst, seen;
  logic [12:0] pf_pc, ret_pc, vec_pc;
  int err_count = 0;
  int tests_run = 0;
  int n;
  int c0;
  int clr_cnt = 0;
  // sweep table: source, control, enable on, wake expected
  int src [11] = '{4, 4, 2, 2, 3, 3, 5, 6, 1, 0, 7};
  logic [3:0] ctl [11] = '{4'h0, 4'h1, 4'h0, 4'h4, 4'h0, 4'h8, 4'h0, 4'h0,
    4'h0, 4'h0, 4'h0};
  logic [10:0] en_on = 11'h7FE;
  logic [10:0] wake = 11'h3EA;
  always #20 clk_in = ~clk_in;
  // count watchdog clear pulses as the design's flops would see them
  always @(posedge clk_in) begin
    if (wclr === 1'b1) begin
      clr_cnt <= clr_cnt + 1;
    end
  end
  sleep_wakeup_control dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .external_reset_pin_n_in(pin_n), .reg_req_in(req), .reg_rdata_out(rdata),
    .core_evt_in(evt), .irq_event_in(irq), .watchdog_timeout_in(wdt_to),
    .core_reset_out(core_rst), .osc_driver_on_out(osc_on),
    .exec_enable_out(exec_en), .phase_tick_out(tick),
    .watchdog_counter_clear_out(wclr), .prefetch_out(pf),
    .prefetch_pc_out(pf_pc), .vector_out(vec), .return_pc_out(ret_pc),
    .vector_pc_out(vec_pc), .nop_cycle_out(nop), .watchdog_reset_out(wrst));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask
  // op 0 sleep, 1 watchdog clear, 2 two-cycle; held to the cycle end
  task automatic op(input int kind);
    @(posedge clk_in);
    evt[15:13] <= 3'b100 >> kind;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
      if (n > 8) begin
        check("op tick", 1, 0);
        tally_and_finish();
      end
    end while (!(tick === 1'b1 && exec_en === 1'b1));
    @(posedge clk_in);
    evt[15:13] <= 3'b000;
  endtask
  // a time-out here after 1500 cycles means the core never restarted
  task automatic wait_exec;
    n = 0;
    while (exec_en !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > 1500) begin
        check("wake", 1, 0);
        tally_and_finish();
      end
    end
  endtask
  // watch a pulse output for a number of cycles
  task automatic watch(ref logic s, input int cyc);
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge clk_in);
      if (s === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic pulse_irq(input int i);
    @(posedge clk_in);
    irq[i] <= 1'b1;
    @(posedge clk_in);
    irq <= 8'h00;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset();
    rd(`SW_REG_STATUS, rv);
    check("status reset", 32'h0000_0003, rv);
    check("return pc", 32'h0000_0101, ret_pc);
    check("vector pc", 32'h0000_0004, vec_pc);
    rd(4'h2, rv);
    check("unmapped", 32'h0000_0000, rv);
    op(2);
    watch(nop, 8);
    check("nop cycle", 1, seen);
    // sweep of wake sources, modes and enables
    for (int i = 0; i < 11; i++) begin
      do_reset();
      wr(`SW_REG_CTRL, {28'h0, ctl[i]});
      wr(`SW_REG_ENABLE, 32'(en_on[i]) << src[i]);
      c0 = clr_cnt;
      op(0);
      rd(`SW_REG_STATUS, rv);
      check("asleep status", 3'b110, rv[2:0]);
      check("sleep clears watchdog", c0 + 1, clr_cnt);
      check("prefetch pc", 32'h0000_0101, pf_pc);
      pulse_irq(src[i]);
      if (wake[i]) begin
        wait_exec();
        check("start-up hold", 1, n >= `SW_OST_CYC);
        watch(vec, 40);
        check("vector", ctl[i][0], seen);
      end else begin
        repeat (60) @(negedge clk_in);
        check("still asleep", 0, osc_on);
      end
    end
    // pending enabled flag with master enable clear
    do_reset();
    wr(`SW_REG_ENABLE, 32'h0000_0010);
    pulse_irq(4);
    rd(`SW_REG_FLAGS, rv);
    check("flag set", 1, rv[4]);
    c0 = clr_cnt;
    op(0);
    rd(`SW_REG_STATUS, rv);
    check("sleep as nop", 2'b11, rv[1:0]);
    check("nop keeps watchdog", c0, clr_cnt);
    // watchdog wake, then time-out while running
    do_reset();
    wr(`SW_REG_CTRL, 32'h0000_0002);
    op(1);
    op(0);
    @(posedge clk_in);
    wdt_to <= 1'b1;
    repeat (4) @(posedge clk_in);
    wdt_to <= 1'b0;
    wait_exec();
    rd(`SW_REG_STATUS, rv);
    check("watchdog wake status", 2'b00, rv[1:0]);
    @(posedge clk_in);
    wdt_to <= 1'b1;
    repeat (4) @(posedge clk_in);
    wdt_to <= 1'b0;
    watch(wrst, 20);
    check("watchdog reset", 1, seen);
    // external pin while asleep
    do_reset();
    wr(`SW_REG_ENABLE, 32'h0000_0002);
    op(0);
    @(posedge clk_in);
    pin_n <= 1'b0;
    watch(core_rst, 10);
    check("pin reset", 1, seen);
    @(posedge clk_in);
    pin_n <= 1'b1;
    wait_exec();
    rd(`SW_REG_ENABLE, rv);
    check("pin reset clears", 32'h0000_0000, rv);
    tally_and_finish();
  end
endmodule // sleep_wakeup_control_bench
`default_nettype wire
